// File: design/rth_sequencer.sv
// Return-to-home sequencer top with register port and interrupt
//
// Notes on behaviour
// - Request while ready starts homing in two- or three-sensor mode; push mode only sets the error bit
// - Ready drops at start; host then releases
// - Origin-done asserted when homing completes
// - Final speed is start speed, capped 500 Hz
// - Start at start speed; three-sensor search at run, two-sensor at start
// - Three-sensor mode works without limit sensors
// - Qualifier enabled: keep moving past origin edge
// - Three-sensor: finish only if qualifier seen on origin
// - Two-sensor: reverse at limit until released
// - Then 200 more steps; stop is origin
// - Qualifier: pause after 200, then seek qualifier
// - Decelerate after origin; may overshoot sensor
// - Mode codes: 0 two, 1 three, 2 push
// - Direction 0 negative, 1 positive; default positive
// - Three-sensor: run speed, stop on origin
// - Offset move after origin gives electrical origin
`timescale 1ns/100ps
`include "rth_regs.svh"
module rth_sequencer
    import rth_pkg::*;
#(
    parameter int PAUSE_CYC = `RTH_PAUSE_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        home_req,
    input  wire logic        origin_sensor,
    input  wire logic        slot_sensor,
    input  wire logic        encoder_phase_signal,
    input  wire logic        pos_limit_sensor,
    input  wire logic        neg_limit_sensor,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             ready,
    output logic             origin_done,
    output logic             step_out,
    output logic             dir_out,
    output logic             irq
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The pause shares the 24-bit step counter
    if (PAUSE_CYC < 1 || PAUSE_CYC > 24'hFFFFFF) begin : g_chk
        $error("PAUSE_CYC out of range");
    end

    localparam logic [23:0] PAUSE_LAST = 24'(PAUSE_CYC - 1);

    // Final approach speed: start speed, capped
    function automatic rth_speed_t final_speed(input rth_speed_t s);
        final_speed = (s < `RTH_FINAL_CAP_HZ) ? s : `RTH_FINAL_CAP_HZ;
    endfunction

    // Magnitude of a signed 24-bit step offset
    function automatic logic [23:0] mag24(input logic [23:0] v);
        mag24 = v[23] ? (~v + 24'h000001) : v;
    endfunction

    rth_seq_s   q;
    rth_seq_s   d;
    rth_step_if st_if ();

    logic        qual_en;
    logic        qual_hit;
    logic        lim_ahead;
    logic        lim_behind;
    logic        origin_rise;
    logic        three;
    logic [2:0]  events;
    logic [2:0]  rd_clr;
    logic [23:0] cnt_nx;

    // ------------------------------------------------------------
    // Step generator
    // ------------------------------------------------------------
    rth_step_gen u_gen (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .st      (st_if.gen)
    );

    assign st_if.run        = q.run;
    assign st_if.dir        = q.dir;
    assign st_if.start_spd  = q.start_spd;
    assign st_if.target_spd = q.target;
    assign st_if.ramp_div   = q.ramp_div;

    // ------------------------------------------------------------
    // Sensor decode
    // ------------------------------------------------------------
    // With both qualifiers enabled both must be seen together
    assign qual_en     = q.slot_en | q.phase_en;
    assign qual_hit    = qual_en & (~q.slot_en | slot_sensor)
                       & (~q.phase_en | encoder_phase_signal);
    assign lim_ahead   = q.dir ? pos_limit_sensor : neg_limit_sensor;
    assign lim_behind  = q.dir ? neg_limit_sensor : pos_limit_sensor;
    assign origin_rise = origin_sensor & ~q.origin_q;
    assign three       = (q.mode == RTH_MODE_THREE);
    assign cnt_nx      = q.cnt + 24'h000001;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d          = q;
        events     = 3'h0;
        d.origin_q = origin_sensor;
        d.step_o   = st_if.step;
        d.dir_o    = q.dir;

        // Command position follows every issued step
        if (st_if.step) begin
            d.pos = q.dir ? q.pos + 32'h00000001 : q.pos - 32'h00000001;
        end

        case (q.state)
            RTH_IDLE: begin
                // Host is expected to see ready before it asks
                if (home_req && q.ready) begin
                    if (q.mode == RTH_MODE_TWO || three) begin
                        d.ready  = 1'b0;
                        d.done   = 1'b0;
                        d.dir    = q.sdir;
                        d.run    = 1'b1;
                        // Two-sensor search is slow, three-sensor fast
                        d.target = three ? q.run_spd : q.start_spd;
                        d.state  = RTH_SEEK;
                        events[`RTH_STAT_START_BIT] = 1'b1;
                    end else begin
                        // Push mode is not served here
                        events[`RTH_STAT_ERR_BIT] = 1'b1;
                    end
                end
            end
            RTH_SEEK: begin
                if (three && origin_rise) begin
                    if (qual_en) begin
                        d.target = final_speed(q.start_spd);
                        d.state  = RTH_QUAL;
                    end else begin
                        d.run   = 1'b0;
                        d.state = RTH_STOP;
                    end
                end else if (lim_ahead) begin
                    // No limit wired just means no reversal here
                    d.run   = 1'b0;
                    d.ret   = three ? RTH_SEEK : RTH_ESCAPE;
                    d.state = RTH_TURN;
                end
            end
            RTH_TURN: begin
                // Reverse only once the motor has come to rest
                if (st_if.idle) begin
                    d.dir    = ~q.dir;
                    d.run    = 1'b1;
                    d.target = three ? q.run_spd : q.start_spd;
                    d.state  = q.ret;
                end
            end
            RTH_ESCAPE: begin
                if (!lim_behind) begin
                    d.cnt   = 24'h000000;
                    d.state = RTH_STEPS;
                end
            end
            RTH_STEPS: begin
                if (st_if.step) begin
                    d.cnt = cnt_nx;
                    if (cnt_nx == `RTH_ESCAPE_STEPS) begin
                        // At start speed the stop is immediate
                        d.run   = 1'b0;
                        d.cnt   = 24'h000000;
                        d.state = qual_en ? RTH_PAUSE : RTH_STOP;
                    end
                end
            end
            RTH_PAUSE: begin
                if (q.cnt != PAUSE_LAST) begin
                    d.cnt = cnt_nx;
                end else if (st_if.idle) begin
                    d.run    = 1'b1;
                    d.target = final_speed(q.start_spd);
                    d.state  = RTH_QUAL;
                end
            end
            RTH_QUAL: begin
                // Three-sensor needs the origin still active
                if (qual_hit && (!three || origin_sensor)) begin
                    d.run   = 1'b0;
                    d.state = RTH_STOP;
                end else if (three && !origin_sensor) begin
                    // Slipped off the origin: look for the next edge
                    d.target = q.run_spd;
                    d.state  = RTH_SEEK;
                end else if (lim_ahead) begin
                    d.run   = 1'b0;
                    d.ret   = three ? RTH_SEEK : RTH_QUAL;
                    d.state = RTH_TURN;
                end
            end
            RTH_STOP: begin
                // Ramp-down may carry the stop past the sensor
                if (st_if.idle) begin
                    if (q.offset != 24'h000000) begin
                        d.dir    = ~q.offset[23];
                        d.cnt    = 24'h000000;
                        d.target = q.start_spd;
                        d.run    = 1'b1;
                        d.state  = RTH_OFFSET;
                    end else begin
                        d.state = RTH_ZERO;
                    end
                end
            end
            RTH_OFFSET: begin
                if (st_if.step) begin
                    d.cnt = cnt_nx;
                    if (cnt_nx == mag24(q.offset)) begin
                        d.run   = 1'b0;
                        d.state = RTH_ZERO;
                    end
                end
            end
            RTH_ZERO: begin
                if (st_if.idle) begin
                    d.pos   = 32'h00000000;
                    d.state = RTH_DONE;
                end
            end
            RTH_DONE: begin
                d.done  = 1'b1;
                d.ready = 1'b1;
                d.state = RTH_IDLE;
                events[`RTH_STAT_DONE_BIT] = 1'b1;
            end
            default: begin
                d.run   = 1'b0;
                d.state = RTH_IDLE;
            end
        endcase

        // Register writes; configuration is taken at any time, but
        // speeds are sampled by the generator as it runs
        if (reg_wr) begin
            case (reg_addr)
                `RTH_ADDR_CTRL: begin
                    d.mode     = reg_wdata[`RTH_CTRL_MODE_MSB:
                                           `RTH_CTRL_MODE_LSB];
                    d.sdir     = reg_wdata[`RTH_CTRL_DIR_BIT];
                    d.slot_en  = reg_wdata[`RTH_CTRL_SLOT_BIT];
                    d.phase_en = reg_wdata[`RTH_CTRL_PHASE_BIT];
                end
                `RTH_ADDR_START_SPD: d.start_spd = reg_wdata[19:0];
                `RTH_ADDR_RUN_SPD:   d.run_spd   = reg_wdata[19:0];
                `RTH_ADDR_RAMP_DIV:  d.ramp_div  = reg_wdata[15:0];
                `RTH_ADDR_OFFSET:    d.offset    = reg_wdata[23:0];
                `RTH_ADDR_IRQ_MASK:  d.mask      = reg_wdata[2:0];
                default: begin
                end
            endcase
        end

        // Read data, valid only in the cycle after the strobe
        d.rdata = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                `RTH_ADDR_CTRL:      d.rdata = {27'h0000000, q.phase_en,
                                                q.slot_en, q.sdir, q.mode};
                `RTH_ADDR_START_SPD: d.rdata = {12'h000, q.start_spd};
                `RTH_ADDR_RUN_SPD:   d.rdata = {12'h000, q.run_spd};
                `RTH_ADDR_RAMP_DIV:  d.rdata = {16'h0000, q.ramp_div};
                `RTH_ADDR_OFFSET:    d.rdata = {8'h00, q.offset};
                `RTH_ADDR_STATUS:    d.rdata = {29'h00000000, q.status};
                `RTH_ADDR_IRQ_MASK:  d.rdata = {29'h00000000, q.mask};
                `RTH_ADDR_POSITION:  d.rdata = q.pos;
                `RTH_ADDR_STATE:     d.rdata = {28'h0000000, q.state};
                default:             d.rdata = 32'h00000000;
            endcase
        end

        // Sticky status; a new event beats the read-to-clear
        rd_clr   = (reg_rd && reg_addr == `RTH_ADDR_STATUS) ? 3'h7 : 3'h0;
        d.status = (q.status & ~rd_clr) | events;
        d.irq    = |(d.status & d.mask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            q           <= '0;
            q.ready     <= 1'b1;
            q.mode      <= `RTH_RST_MODE;
            q.sdir      <= `RTH_RST_DIR;
            q.start_spd <= `RTH_RST_START_SPD;
            q.run_spd   <= `RTH_RST_RUN_SPD;
            q.ramp_div  <= `RTH_RST_RAMP_DIV;
            q.offset    <= `RTH_RST_OFFSET;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata   = q.rdata;
    assign ready       = q.ready;
    assign origin_done = q.done;
    assign step_out    = q.step_o;
    assign dir_out     = q.dir_o;
    assign irq         = q.irq;

endmodule

// File: design/rth_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RTH_REGS_SVH
`define RTH_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RTH_ADDR_CTRL      8'h00
`define RTH_ADDR_START_SPD 8'h04
`define RTH_ADDR_RUN_SPD   8'h08
`define RTH_ADDR_RAMP_DIV  8'h0C
`define RTH_ADDR_OFFSET    8'h10
`define RTH_ADDR_STATUS    8'h14
`define RTH_ADDR_IRQ_MASK  8'h18
`define RTH_ADDR_POSITION  8'h1C
`define RTH_ADDR_STATE     8'h20

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define RTH_CTRL_MODE_LSB  0
`define RTH_CTRL_MODE_MSB  1
`define RTH_CTRL_DIR_BIT   2
`define RTH_CTRL_SLOT_BIT  3
`define RTH_CTRL_PHASE_BIT 4

// Status bits: started, done, unsupported mode
`define RTH_STAT_START_BIT 0
`define RTH_STAT_DONE_BIT  1
`define RTH_STAT_ERR_BIT   2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RTH_RST_MODE       2'h1
`define RTH_RST_DIR        1'h1
`define RTH_RST_START_SPD  20'h001F4
`define RTH_RST_RUN_SPD    20'h003E8
`define RTH_RST_RAMP_DIV   16'h0032
`define RTH_RST_OFFSET     24'h000000

// ----------------------------------------------------------------
// Timing and motion constants
// ----------------------------------------------------------------
`define RTH_CLK_HZ         27'h2FAF080
`define RTH_CLK_NS         20
`define RTH_FINAL_CAP_HZ   20'h001F4
`define RTH_ESCAPE_STEPS   24'h0000C8
`define RTH_PAUSE_NS       1000000
`define RTH_PAUSE_CYC      ((`RTH_PAUSE_NS + `RTH_CLK_NS - 1) / `RTH_CLK_NS)

`endif

// File: design/rth_pkg.sv
// Types shared by the return-to-home sequencer and its step generator
package rth_pkg;

    typedef logic [19:0] rth_speed_t;

    // Homing mode codes
    typedef enum logic [1:0] {
        RTH_MODE_TWO   = 2'h0,
        RTH_MODE_THREE = 2'h1,
        RTH_MODE_PUSH  = 2'h2
    } rth_mode_e;

    // Sequencer states
    typedef enum logic [3:0] {
        RTH_IDLE   = 4'h0,
        RTH_SEEK   = 4'h1,
        RTH_TURN   = 4'h2,
        RTH_ESCAPE = 4'h3,
        RTH_STEPS  = 4'h4,
        RTH_PAUSE  = 4'h5,
        RTH_QUAL   = 4'h6,
        RTH_STOP   = 4'h7,
        RTH_OFFSET = 4'h8,
        RTH_ZERO   = 4'h9,
        RTH_DONE   = 4'hA
    } rth_state_e;

    typedef struct packed {
        rth_state_e  state;
        rth_state_e  ret;
        logic        run;
        logic        dir;
        rth_speed_t  target;
        logic [23:0] cnt;
        logic [31:0] pos;
        logic        origin_q;
        logic        ready;
        logic        done;
        logic        step_o;
        logic        dir_o;
        logic        irq;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic [1:0]  mode;
        logic        sdir;
        logic        slot_en;
        logic        phase_en;
        rth_speed_t  start_spd;
        rth_speed_t  run_spd;
        logic [15:0] ramp_div;
        logic [23:0] offset;
        logic [31:0] rdata;
    } rth_seq_s;

    typedef struct packed {
        rth_speed_t  cur;
        logic [26:0] acc;
        logic [15:0] div;
        logic        step;
        logic        busy;
    } rth_gen_s;

endpackage

// File: design/rth_step_if.sv
// Motion command link between sequencer and step generator
`timescale 1ns/100ps
interface rth_step_if;
    import rth_pkg::*;
    logic        run;
    logic        dir;
    rth_speed_t  start_spd;
    rth_speed_t  target_spd;
    logic [15:0] ramp_div;
    logic        step;
    logic        idle;

    modport seq (output run, dir, start_spd, target_spd, ramp_div,
                 input  step, idle);
    modport gen (input  run, dir, start_spd, target_spd, ramp_div,
                 output step, idle);
endinterface

// File: design/rth_step_gen.sv
// Step pulse generator with linear speed ramp
`timescale 1ns/100ps
`include "rth_regs.svh"
module rth_step_gen
    import rth_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset_n,
    rth_step_if.gen   st
);

    rth_gen_s    g_q;
    rth_gen_s    g_d;
    rth_speed_t  tgt;
    logic [26:0] sum;

    // ------------------------------------------------------------
    // Ramp and phase accumulator
    // ------------------------------------------------------------
    // Speed moves 1 Hz per ramp_div+1 clocks; stopping ramps down to
    // the start speed, so a move run at start speed stops at once
    always_comb begin
        g_d      = g_q;
        g_d.step = 1'b0;
        tgt      = st.run ? st.target_spd : st.start_spd;
        sum      = g_q.acc + {7'h00, g_q.cur};
        if (st.run && !g_q.busy) begin
            g_d.busy = 1'b1;
            g_d.cur  = st.start_spd;
            g_d.acc  = 27'h0000000;
            g_d.div  = 16'h0000;
        end else if (g_q.busy) begin
            if (!st.run && g_q.cur <= st.start_spd) begin
                g_d.busy = 1'b0;
                g_d.cur  = 20'h00000;
            end else begin
                if (g_q.div >= st.ramp_div) begin
                    g_d.div = 16'h0000;
                    if (g_q.cur < tgt) begin
                        g_d.cur = g_q.cur + 20'h00001;
                    end else if (g_q.cur > tgt) begin
                        g_d.cur = g_q.cur - 20'h00001;
                    end
                end else begin
                    g_d.div = g_q.div + 16'h0001;
                end
                if (sum >= `RTH_CLK_HZ) begin
                    g_d.acc  = sum - `RTH_CLK_HZ;
                    g_d.step = 1'b1;
                end else begin
                    g_d.acc = sum;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            g_q <= '0;
        end else begin
            g_q <= g_d;
        end
    end

    assign st.step = g_q.step;
    assign st.idle = ~g_q.busy;

endmodule

// File: tb/rth_assertions.sv
// Concurrent checks on the homing sequencer ports
`timescale 1ns/100ps
module rth_assertions (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        home_req,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        ready,
    input  wire logic        origin_done,
    input  wire logic        step_out
);
    // --------
    // Handshake and output timing
    // --------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    property p_start;
        ready && home_req |=> !ready && !origin_done;
    endproperty
    a_start: assert property (p_start)
        else $error("home request not taken");

    property p_busy;
        $fell(ready) |-> !ready [*8];
    endproperty
    a_busy: assert property (p_busy)
        else $error("ready came back too soon");

    property p_done_ready;
        origin_done |-> ready;
    endproperty
    a_done_ready: assert property (p_done_ready)
        else $error("origin done while busy");

    property p_ready_rise;
        $rose(ready) |-> origin_done;
    endproperty
    a_ready_rise: assert property (p_ready_rise)
        else $error("ready back without origin done");

    property p_done_hold;
        origin_done && !home_req |=> origin_done;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("origin done dropped early");

    // Steps belong to an operation, never to idle
    property p_idle_quiet;
        ready |-> !step_out;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("step while idle");

    // Even the top rate leaves dozens of clocks between pulses
    property p_step_pulse;
        step_out |=> !step_out [*8];
    endproperty
    a_step_pulse: assert property (p_step_pulse)
        else $error("step pulses too close");

    property p_rd_idle;
        !reg_rd |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
endmodule

bind rth_sequencer rth_assertions u_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .home_req(home_req),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ready(ready),
    .origin_done(origin_done), .step_out(step_out)
);

// File: tb/rth_mech_model.sv
// Mechanism model: step counter carrying origin, limit and qualifiers
`timescale 1ns/100ps
module rth_mech_model (
    input  wire logic               clk_sys,
    input  wire logic               step_out,
    input  wire logic               dir_out,
    input  wire logic signed [31:0] org_at,
    input  wire logic signed [31:0] lp_at,
    input  wire logic signed [31:0] ln_at,
    output logic signed      [31:0] pos,
    output logic                    origin_sensor,
    output logic                    slot_sensor,
    output logic                    encoder_phase_signal,
    output logic                    pos_limit_sensor,
    output logic                    neg_limit_sensor
);
    // --------
    // Carriage position and sensor levels
    // --------
    initial pos = 32'sh0000_0000;

    // One step per pulse; no inertia so counts stay exact
    always @(posedge clk_sys) begin
        if (step_out === 1'b1) begin
            pos <= dir_out ? pos + 1 : pos - 1;
        end
    end

    // Origin flag is ten steps wide, limits cover everything beyond
    assign origin_sensor = (pos >= org_at) && (pos < org_at + 10);
    assign slot_sensor = origin_sensor && pos[0];
    assign encoder_phase_signal = pos[1];
    assign pos_limit_sensor = pos >= lp_at;
    assign neg_limit_sensor = pos <= ln_at;
endmodule

// File: tb/rth_sequencer_bench.sv
// Self-checking bench for the return-to-home sequencer
`timescale 1ns/100ps
`include "rth_regs.svh"
module rth_sequencer_bench;
    import rth_pkg::*;
    logic               clk_sys, reset_n, home_req, reg_wr, reg_rd, rd_q;
    logic               org_s, slot_s, ph_s, limp_s, limn_s;
    logic               ready, origin_done, step_out, dir_out, irq;
    logic        [7:0]  reg_addr;
    logic        [31:0] reg_wdata, reg_rdata;
    logic        [31:0] exp_q[$];
    logic signed [31:0] pos, org_at, lp_at, ln_at, off;
    logic        [15:0] rnd;
    int                 err_count, total_checks, n;

    rth_sequencer #(.PAUSE_CYC(4)) uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .home_req(home_req),
        .origin_sensor(org_s), .slot_sensor(slot_s),
        .encoder_phase_signal(ph_s), .pos_limit_sensor(limp_s),
        .neg_limit_sensor(limn_s), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ready(ready), .origin_done(origin_done),
        .step_out(step_out), .dir_out(dir_out), .irq(irq)
    );

    rth_mech_model mech (
        .clk_sys(clk_sys), .step_out(step_out), .dir_out(dir_out),
        .org_at(org_at), .lp_at(lp_at), .ln_at(ln_at), .pos(pos),
        .origin_sensor(org_s), .slot_sensor(slot_s),
        .encoder_phase_signal(ph_s), .pos_limit_sensor(limp_s),
        .neg_limit_sensor(limn_s)
    );

    // --------
    // Clock, helpers and scoreboard
    // --------
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Expectation is queued before the strobe so the watcher finds it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask

    // Read word stands only in the cycle after the strobe
    always @(posedge clk_sys) begin
        rd_q <= reg_rd;
        if (rd_q && exp_q.size() > 0) begin
            chk(reg_rdata, exp_q.pop_front(), "read data");
        end
    end

    // Full homing run; host lets go only after ready drops
    task automatic go(input logic [31:0] ctrl, input logic e_irq);
        wr(`RTH_ADDR_CTRL, ctrl);
        #1;
        chk(ready, 1'b1, "ready before request");
        @(posedge clk_sys);
        home_req <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (ready !== 1'b0 && n < 20);
        chk(ready, 1'b0, "ready dropped");
        @(posedge clk_sys);
        home_req <= 1'b0;
        n = 0;
        while (origin_done !== 1'b1 && n < 60000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(origin_done, 1'b1, "origin done");
        if (n >= 60000) complete_run();
        chk(irq, e_irq, "irq level");
        rd(`RTH_ADDR_STATUS, 32'h0000_0003);
        rd(`RTH_ADDR_POSITION, 32'h0000_0000);
        repeat (3) @(posedge clk_sys);
        #1;
        chk(irq, 1'b0, "irq after clear");
    endtask

    // --------
    // Main sequence
    // --------
    initial begin
        reset_n = 1'b0;
        home_req = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rd_q = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        org_at = 30;
        lp_at = 1000;
        ln_at = -1000;
        err_count = 0;
        total_checks = 0;
        rnd = 16'hE148;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        // Defaults, then an unmapped place that must read zero
        rd(`RTH_ADDR_CTRL, 32'h0000_0005);
        rd(`RTH_ADDR_START_SPD, 32'h0000_01F4);
        rd(`RTH_ADDR_RUN_SPD, 32'h0000_03E8);
        rd(`RTH_ADDR_OFFSET, 32'h0000_0000);
        rd(8'h24, 32'h0000_0000);
        rnd = lfsr(rnd);
        wr(`RTH_ADDR_OFFSET, {9'h000, rnd, 7'h00});
        rd(`RTH_ADDR_OFFSET, {9'h000, rnd, 7'h00});
        // Fast speeds keep each run far inside the 60000-clock limit
        wr(`RTH_ADDR_START_SPD, 32'h000F_4240);
        wr(`RTH_ADDR_RUN_SPD, 32'h000F_4240);
        rnd = lfsr(rnd);
        off = 32'(rnd[2:0]) + 1;
        wr(`RTH_ADDR_OFFSET, off);
        wr(`RTH_ADDR_IRQ_MASK, 32'h0000_0007);
        // Three sensors, positive start, origin straight ahead
        go(32'h0000_0005, 1'b1);
        chk(pos >= org_at + off && pos <= org_at + off + 3, 1'b1,
            "stop past origin");
        // Negative start meets its limit first and turns back
        org_at = pos + 40;
        ln_at = pos - 20;
        lp_at = pos + 1000;
        go(32'h0000_0001, 1'b1);
        chk(pos >= org_at + off && pos <= org_at + off + 3, 1'b1,
            "origin after turn");
        // Two sensors, masked interrupt, escape then fixed count
        lp_at = pos + 50;
        ln_at = pos - 1000;
        org_at = pos + 5000;
        wr(`RTH_ADDR_OFFSET, 32'h0000_0000);
        wr(`RTH_ADDR_IRQ_MASK, 32'h0000_0000);
        go(32'h0000_0004, 1'b0);
        chk(pos, lp_at - 1 - 200, "escape end");
        // Slot qualifier: even origin edge, slot one step further on
        org_at = pos + 40 - pos[0];
        go(32'h0000_000D, 1'b0);
        chk(pos, org_at + 1, "slot past origin");
        complete_run();
    end
endmodule
